// *** src/dsp_serial_access.sv ***
// Serial parameter access, fault latch and ready logic of the drive.
module dsp_serial_access
   import dsp_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic rxValid,
   input wire logic [7:0] rxChar,
   output logic rxReady,
   output logic txValid,
   output logic [7:0] txByte,
   input wire logic txReady,
   input wire logic [7:0] faultIn,
   input wire logic driveEnablePin,
   input wire logic supplyPresentPin,
   input wire logic cancelErrorPin,
   input wire logic readyUndervoltageSelect,
   input wire logic [15:0] speedActual,
   output logic readyContact,
   output logic readyStatus,
   output logic faultLed,
   output logic driveGo,
   output dsp_cur_ctrl_s curCtrl,
   output dsp_can_cfg_s canCfg
);

   typedef enum logic [1:0] {ST_RECV, ST_LOOK, ST_SEND} dsp_state_e;

   // ------------------------------------------------------------------
   // Decoding helpers
   // ------------------------------------------------------------------

   // Maps a parameter number to its storage slot; bit 4 flags a hit.
   function automatic logic [4:0] slotOf(input logic [7:0] id);
      logic [4:0] res;
      res = 5'h00;
      for (int k = 0; k < N_PARAMS; k++) begin
         if (id == PARAM_ID[k]) begin
            res = {1'b1, 4'(k)};
         end
      end
      return res;
   endfunction

   // Returns a hit flag and the nibble value of an ASCII hex character.
   function automatic logic [4:0] hexOf(input logic [7:0] c);
      logic [4:0] res;
      res = 5'h00;
      if (c >= CHR_DIG0 && c <= CHR_DIG9) begin
         res = {1'b1, 4'(c - CHR_DIG0)};
      end else if (c >= CHR_UPA && c <= CHR_UPF) begin
         res = {1'b1, 4'(c - CHR_UPA + 8'h0a)};
      end else if (c >= CHR_LOA && c <= CHR_LOF) begin
         res = {1'b1, 4'(c - CHR_LOA + 8'h0a)};
      end
      return res;
   endfunction

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   logic [2:0] pinMeta_ff;
   logic [2:0] pinSync_ff;
   logic [2:0] nxt_pinMeta;
   logic [2:0] nxt_pinSync;
   logic enSync;
   logic supplySync;
   logic cancelSync;

   // Enable, supply sense and cancel input come from outside the clock.
   always_comb begin
      nxt_pinMeta = {cancelErrorPin, supplyPresentPin, driveEnablePin};
      nxt_pinSync = pinMeta_ff;
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pinMeta_ff <= 3'h0;
         pinSync_ff <= 3'h0;
      end else begin
         pinMeta_ff <= nxt_pinMeta;
         pinSync_ff <= nxt_pinSync;
      end
   end

   assign enSync = pinSync_ff[0];
   assign supplySync = pinSync_ff[1];
   assign cancelSync = pinSync_ff[2];

   // ------------------------------------------------------------------
   // Request parser and reply sequencer
   // ------------------------------------------------------------------
   dsp_state_e state_ff;
   dsp_state_e nxt_state;
   logic [3:0] charCnt_ff;
   logic [3:0] nxt_charCnt;
   logic [39:0] shift_ff;
   logic [39:0] nxt_shift;
   logic bad_ff;
   logic nxt_bad;
   logic [7:0] rdId_ff;
   logic [7:0] nxt_rdId;
   logic [2:0] left_ff;
   logic [2:0] nxt_left;
   logic [31:0] reply_ff;
   logic [31:0] nxt_reply;
   logic [4:0] rxNib;
   logic [7:0] frameSel;
   logic [15:0] frameData;
   logic frameOk;
   logic frameLong;
   logic [4:0] rdHit;
   logic [4:0] wrHit;
   logic memWrEn;
   dsp_word_t memWrData;
   dsp_word_t memRdData;
   dsp_word_t liveWord;
   dsp_word_t params [N_PARAMS];
   logic cancelCmd;
   logic [15:0] statusWord;
   logic [15:0] speedScaled;
   logic fault_ff;
   logic go_ff;

   assign rxNib = hexOf(rxChar);
   assign frameLong = (charCnt_ff == NIB_LONG);
   assign frameSel = frameLong ? shift_ff[39:32] : shift_ff[23:16];
   assign frameData = shift_ff[15:0];
   // A frame counts only when X ends exactly 6 or 10 clean nibbles.
   assign frameOk = rxValid && rxReady && rxChar == CHR_SYNC && !bad_ff &&
      (charCnt_ff == NIB_SHORT || frameLong);
   assign rdHit = slotOf(frameData[7:0]);
   assign wrHit = slotOf(frameSel);
   assign memWrEn = frameOk && frameSel != SEL_READ && wrHit[4];
   // Integral memory limit writes above 100 % are held at the top of the range.
   assign memWrData = (frameSel == PARAM_ID[SLOT_IMEM] &&
      frameData > IMEM_MAX) ? IMEM_MAX : frameData;
   assign cancelCmd = frameOk && frameSel == ID_CANCEL;

   // Full-scale negative rail is folded onto -32767 for symmetry.
   assign speedScaled = (speedActual == SPEED_NEG_RAIL) ?
      SPEED_NEG_FULL : speedActual;

   // Values that do not live in the store are picked here.
   always_comb begin
      case (rdId_ff)
         ID_SPEED: liveWord = speedScaled;
         ID_STATUS: liveWord = statusWord;
         ID_GO: liveWord = 16'(go_ff);
         default: liveWord = memRdData;
      endcase
   end

   // Characters are refused while a reply is still being sent.
   assign rxReady = (state_ff == ST_RECV);
   assign txValid = (state_ff == ST_SEND);
   assign txByte = reply_ff[7:0];

   always_comb begin
      nxt_state = state_ff;
      nxt_charCnt = charCnt_ff;
      nxt_shift = shift_ff;
      nxt_bad = bad_ff;
      nxt_rdId = rdId_ff;
      nxt_left = left_ff;
      nxt_reply = reply_ff;
      case (state_ff)
         ST_RECV: begin
            if (rxValid) begin
               if (rxChar == CHR_SYNC) begin
                  // Any sync ends the frame; only clean ones are served.
                  nxt_charCnt = 4'h0;
                  nxt_bad = 1'b0;
                  if (frameOk && frameSel == SEL_READ) begin
                     nxt_rdId = frameData[7:0];
                     nxt_left = frameLong ? REPLY_LONG : REPLY_SHORT;
                     nxt_state = ST_LOOK;
                  end
               end else begin
                  nxt_shift = {shift_ff[35:0], rxNib[3:0]};
                  if (!rxNib[4]) begin
                     nxt_bad = 1'b1;
                  end
                  if (charCnt_ff == NIB_OVER) begin
                     nxt_bad = 1'b1;
                  end else begin
                     nxt_charCnt = charCnt_ff + 4'h1;
                  end
               end
            end
         end
         ST_LOOK: begin
            // The store's registered read is valid now.
            nxt_reply = {16'h0000, liveWord};
            nxt_state = ST_SEND;
         end
         ST_SEND: begin
            if (txReady) begin
               // Low byte leaves first, higher bytes follow in order.
               nxt_reply = {8'h00, reply_ff[31:8]};
               nxt_left = left_ff - 3'h1;
               if (left_ff == 3'h1) begin
                  nxt_state = ST_RECV;
               end
            end
         end
         default: begin
            nxt_state = ST_RECV;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= ST_RECV;
         charCnt_ff <= 4'h0;
         shift_ff <= 40'h0;
         bad_ff <= 1'b0;
         rdId_ff <= 8'h00;
         left_ff <= 3'h0;
         reply_ff <= 32'h0;
      end else begin
         state_ff <= nxt_state;
         charCnt_ff <= nxt_charCnt;
         shift_ff <= nxt_shift;
         bad_ff <= nxt_bad;
         rdId_ff <= nxt_rdId;
         left_ff <= nxt_left;
         reply_ff <= nxt_reply;
      end
   end

   // ------------------------------------------------------------------
   // Parameter store
   // ------------------------------------------------------------------
   dsp_param_bank u_bank (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .wrEn(memWrEn),
      .wrSlot(wrHit[3:0]),
      .wrData(memWrData),
      .rdSlot(rdHit[4] ? rdHit[3:0] : 4'hf),
      .rdData(memRdData),
      .values(params)
   );

   // Controller parameters leave the store as one bundle.
   always_comb begin
      curCtrl.gain = params[SLOT_GAIN];
      curCtrl.integTime = params[SLOT_INTEG];
      curCtrl.ramp = params[SLOT_RAMP];
      curCtrl.integralMemoryLimit = params[SLOT_IMEM];
      curCtrl.digitalLimit = params[SLOT_DIGLIM];
      curCtrl.peakLimit = params[SLOT_PEAK];
      curCtrl.contLimit = params[SLOT_CONT];
      curCtrl.overcurrentTime = params[SLOT_OCT];
   end

   // CAN identifiers and the rate that the timing code selects.
   always_comb begin
      canCfg.canReceiveIdentifier = params[SLOT_RXID];
      canCfg.canTransmitIdentifier = params[SLOT_TXID];
      canCfg.canBitTimingCode = params[SLOT_BTR];
      case (params[SLOT_BTR])
         BTR_1000K: canCfg.nominalBitRate = KBAUD_1000;
         BTR_500K: canCfg.nominalBitRate = KBAUD_500;
         BTR_625K: canCfg.nominalBitRate = KBAUD_625;
         BTR_250K: canCfg.nominalBitRate = KBAUD_250;
         default: canCfg.nominalBitRate = 16'h0000;
      endcase
   end

   // ------------------------------------------------------------------
   // Fault latch, ready contact and go flag
   // ------------------------------------------------------------------
   logic enPrev_ff;
   logic cancelPrev_ff;
   logic ready_ff;
   logic nxt_fault;
   logic nxt_ready;
   logic nxt_go;
   logic clearEvt;
   logic supplyLost;

   // Power-on is the reset itself, so the latch starts clear.
   assign clearEvt = (enSync && !enPrev_ff) || (cancelSync && !cancelPrev_ff)
      || cancelCmd;
   // Loss needs both enable and supply gone, and only the watchdog sees it.
   assign supplyLost = readyUndervoltageSelect && !enSync && !supplySync;

   always_comb begin
      // A fault in the clearing cycle wins so that no event is lost.
      if (|faultIn) begin
         nxt_fault = 1'b1;
      end else if (clearEvt) begin
         nxt_fault = 1'b0;
      end else begin
         nxt_fault = fault_ff;
      end
      nxt_ready = !nxt_fault && !supplyLost;
      nxt_go = enSync && !nxt_fault;
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         fault_ff <= 1'b0;
         ready_ff <= 1'b0;
         go_ff <= 1'b0;
         enPrev_ff <= 1'b0;
         cancelPrev_ff <= 1'b0;
      end else begin
         fault_ff <= nxt_fault;
         ready_ff <= nxt_ready;
         go_ff <= nxt_go;
         enPrev_ff <= enSync;
         cancelPrev_ff <= cancelSync;
      end
   end

   // Front status word: ready in bit 0, red fault lamp in bit 1.
   always_comb begin
      statusWord = 16'h0000;
      statusWord[STAT_READY_BIT] = ready_ff;
      statusWord[STAT_FAULT_BIT] = fault_ff;
   end

   assign readyContact = ready_ff;
   assign readyStatus = ready_ff;
   assign faultLed = fault_ff;
   assign driveGo = go_ff;

endmodule

// *** src/dsp_pkg.sv ***
// Shared constants, parameter map and carrier types of the serial access block.
package dsp_pkg;

   // ------------------------------------------------------------------
   // Serial frame characters and frame lengths
   // ------------------------------------------------------------------
   localparam logic [7:0] CHR_SYNC = 8'h58; // Upper-case X ends a request.
   localparam logic [7:0] CHR_DIG0 = 8'h30;
   localparam logic [7:0] CHR_DIG9 = 8'h39;
   localparam logic [7:0] CHR_UPA = 8'h41;
   localparam logic [7:0] CHR_UPF = 8'h46;
   localparam logic [7:0] CHR_LOA = 8'h61;
   localparam logic [7:0] CHR_LOF = 8'h66;
   localparam logic [3:0] NIB_SHORT = 4'h6; // Selector plus 16-bit data.
   localparam logic [3:0] NIB_LONG = 4'ha;  // Selector plus 32-bit data.
   localparam logic [3:0] NIB_OVER = 4'hb;  // Too many characters.
   localparam logic [2:0] REPLY_SHORT = 3'h2;
   localparam logic [2:0] REPLY_LONG = 3'h4;
   localparam logic [7:0] SEL_READ = 8'h3d;

   // ------------------------------------------------------------------
   // Parameter numbers
   // ------------------------------------------------------------------
   localparam logic [7:0] ID_SPEED = 8'h30;
   localparam logic [7:0] ID_STATUS = 8'h8f;
   localparam logic [7:0] ID_GO = 8'he3;
   localparam logic [7:0] ID_CANCEL = 8'h8e;
   localparam int N_PARAMS = 11;
   localparam int SLOT_GAIN = 0;
   localparam int SLOT_INTEG = 1;
   localparam int SLOT_RAMP = 2;
   localparam int SLOT_IMEM = 3;
   localparam int SLOT_DIGLIM = 4;
   localparam int SLOT_RXID = 5;
   localparam int SLOT_TXID = 6;
   localparam int SLOT_BTR = 7;
   localparam int SLOT_PEAK = 8;
   localparam int SLOT_CONT = 9;
   localparam int SLOT_OCT = 10;
   localparam logic [7:0] PARAM_ID [N_PARAMS] = '{
      8'h1c, 8'h1d, 8'h25, 8'h2b, 8'h46, 8'h68, 8'h69, 8'h73,
      8'hc4, 8'hc5, 8'hf0};
   localparam logic [15:0] PARAM_RST [N_PARAMS] = '{
      16'h000a, 16'h0258, 16'h0258, 16'h0032, 16'h0064, 16'h0201,
      16'h0181, 16'h4025, 16'h0000, 16'h0000, 16'h0005};
   localparam logic [15:0] IMEM_MAX = 16'h0064; // Upper end of 0..100 %.

   // ------------------------------------------------------------------
   // Status bits, bit-timing codes and rates
   // ------------------------------------------------------------------
   localparam int STAT_READY_BIT = 0;
   localparam int STAT_FAULT_BIT = 1;
   localparam int GO_BIT = 0;
   localparam logic [15:0] BTR_1000K = 16'h4002;
   localparam logic [15:0] BTR_500K = 16'h4025;
   localparam logic [15:0] BTR_625K = 16'h4014;
   localparam logic [15:0] BTR_250K = 16'h402f;
   localparam logic [15:0] KBAUD_1000 = 16'h03e8;
   localparam logic [15:0] KBAUD_500 = 16'h01f4;
   localparam logic [15:0] KBAUD_625 = 16'h0271;
   localparam logic [15:0] KBAUD_250 = 16'h00fa;
   localparam logic [15:0] SPEED_NEG_FULL = 16'h8001; // -32767.
   localparam logic [15:0] SPEED_NEG_RAIL = 16'h8000;

   // ------------------------------------------------------------------
   // Carrier types
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [15:0] gain;
      logic [15:0] integTime;
      logic [15:0] ramp;
      logic [15:0] integralMemoryLimit;
      logic [15:0] digitalLimit;
      logic [15:0] peakLimit;
      logic [15:0] contLimit;
      logic [15:0] overcurrentTime;
   } dsp_cur_ctrl_s;

   typedef struct packed {
      logic [15:0] canReceiveIdentifier;
      logic [15:0] canTransmitIdentifier;
      logic [15:0] canBitTimingCode;
      logic [15:0] nominalBitRate; // kbaud, zero for an unknown code.
   } dsp_can_cfg_s;

   typedef logic [15:0] dsp_word_t;

endpackage

// *** src/dsp_param_bank.sv ***
// Parameter store with reset defaults, one write port and a registered read.
module dsp_param_bank
   import dsp_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic wrEn,
   input wire logic [3:0] wrSlot,
   input wire dsp_word_t wrData,
   input wire logic [3:0] rdSlot,
   output dsp_word_t rdData,
   output dsp_word_t values [N_PARAMS]
);

   // ------------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------------
   dsp_word_t mem_ff [N_PARAMS];
   dsp_word_t nxt_mem [N_PARAMS];
   dsp_word_t rdData_ff;
   dsp_word_t nxt_rdData;

   // Every entry owns its reset default, so a loop builds them all.
   for (genvar i = 0; i < N_PARAMS; i++) begin : g_entry
      always_comb begin
         nxt_mem[i] = mem_ff[i];
         if (wrEn && wrSlot == 4'(i)) begin
            nxt_mem[i] = wrData;
         end
      end

      always_ff @(posedge core_clk or negedge reset_n) begin
         if (!reset_n) begin
            mem_ff[i] <= PARAM_RST[i];
         end else begin
            mem_ff[i] <= nxt_mem[i];
         end
      end

      assign values[i] = mem_ff[i];
   end

   // Read data is registered; slots beyond the table read as zero.
   always_comb begin
      nxt_rdData = '0;
      for (int k = 0; k < N_PARAMS; k++) begin
         if (rdSlot == 4'(k)) begin
            nxt_rdData = mem_ff[k];
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdData_ff <= '0;
      end else begin
         rdData_ff <= nxt_rdData;
      end
   end

   assign rdData = rdData_ff;

endmodule

// *** sim/dsp_chk.sv ***
// Port checker of the serial parameter access block.
module dsp_chk
   import dsp_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic rxValid,
   input wire logic [7:0] rxChar,
   input wire logic rxReady,
   input wire logic txValid,
   input wire logic [7:0] txByte,
   input wire logic txReady,
   input wire logic [7:0] faultIn,
   input wire logic readyUndervoltageSelect,
   input wire logic readyContact,
   input wire logic readyStatus,
   input wire logic faultLed,
   input wire logic driveGo
);
   timeunit 1ns;
   timeprecision 1ps;

   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   // A fault source and a taken sync character start three of the checks.
   sequence faultSeen;
      faultIn != 8'h00;
   endsequence
   sequence syncTaken;
      rxValid && rxReady && rxChar == CHR_SYNC;
   endsequence

   chk_fault_drops_ready: assert property (
      faultSeen |=> !readyContact && !driveGo)
      else $error("ready or go stayed up after a fault");
   chk_fault_lamp_on: assert property (faultSeen |=> faultLed)
      else $error("fault lamp not set");
   chk_go_no_fault: assert property (driveGo |-> !faultLed)
      else $error("go flag up while a fault is latched");
   chk_status_follows: assert property (
      readyStatus == readyContact)
      else $error("ready status differs from ready contact");
   chk_ready_no_fault: assert property (
      readyContact |-> !faultLed)
      else $error("ready contact closed with a fault latched");
   chk_ready_no_watch: assert property (
      !readyUndervoltageSelect && !faultLed && faultIn == 8'h00
      |=> readyContact)
      else $error("ready dropped without watchdog or fault");
   chk_reply_late: assert property (syncTaken |=> !txValid)
      else $error("reply offered too early");
   chk_reply_start: assert property (
      $rose(txValid) |-> $past(rxValid && rxReady && rxChar == CHR_SYNC, 2))
      else $error("reply not two edges after the sync character");
   chk_reply_hold: assert property (
      txValid && !txReady |=> txValid && $stable(txByte))
      else $error("reply byte not held while stalled");
   chk_rx_blocked: assert property (txValid |-> !rxReady)
      else $error("characters accepted during a reply");
endmodule

bind dsp_serial_access dsp_chk chk (
   .core_clk, .reset_n, .rxValid, .rxChar, .rxReady, .txValid, .txByte,
   .txReady, .faultIn, .readyUndervoltageSelect, .readyContact,
   .readyStatus, .faultLed, .driveGo
);

// *** sim/dsp_host_model.sv ***
// Host model that sends ASCII request frames and collects reply bytes.
module dsp_host_model
   import dsp_pkg::*;
(
   input wire logic core_clk,
   output logic rxValid,
   output logic [7:0] rxChar,
   input wire logic rxReady,
   input wire logic txValid,
   input wire logic [7:0] txByte,
   output logic txReady,
   input wire logic slow
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] got [$];
   logic [1:0] phase = 2'h0;

   // Start idle with the sink not yet accepting.
   initial begin
      rxValid = 1'b0;
      rxChar = 8'ha5;
      txReady = 1'b0;
   end

   // Each character is held until taken; the idle line then shows the
   // inverse of the last one so a stale character never looks valid.
   task automatic sendFrame(input string s);
      for (int i = 0; i < s.len(); i++) begin
         rxValid <= 1'b1;
         rxChar <= s[i];
         @(negedge core_clk);
         while (!rxReady) @(negedge core_clk);
         @(posedge core_clk);
      end
      rxValid <= 1'b0;
      rxChar <= ~s[s.len()-1];
      @(posedge core_clk);
   endtask

   // Bytes are queued in arrival order; slow mode takes one cycle in four.
   always @(posedge core_clk) begin
      if (txValid && txReady) got.push_back(txByte);
      phase <= phase + 2'h1;
      txReady <= !slow || phase == 2'h3;
   end
endmodule

// *** sim/tb.sv ***
// Self-checking bench of the serial parameter access block.
module tb
   import dsp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic rxValid, rxReady, txValid, txReady, slow;
   logic [7:0] rxChar, txByte, faultIn;
   logic driveEnablePin, supplyPresentPin, cancelErrorPin;
   logic readyUndervoltageSelect, readyContact, readyStatus;
   logic faultLed, driveGo;
   logic [15:0] speedActual;
   dsp_cur_ctrl_s curCtrl;
   dsp_can_cfg_s canCfg;
   int errTotal = 0;
   int testsRun = 0;

   dsp_serial_access dut (
      .core_clk, .reset_n, .rxValid, .rxChar, .rxReady, .txValid, .txByte,
      .txReady, .faultIn, .driveEnablePin, .supplyPresentPin,
      .cancelErrorPin, .readyUndervoltageSelect, .speedActual,
      .readyContact, .readyStatus, .faultLed, .driveGo, .curCtrl, .canCfg
   );
   dsp_host_model host (
      .core_clk, .rxValid, .rxChar, .rxReady, .txValid, .txByte,
      .txReady, .slow
   );

   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   // Clock of 5 ns period.
   always #2.5 core_clk = ~core_clk;

   // Compare and count.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      testsRun++;
      if (seen !== exp) begin
         errTotal++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   // Print the counts and the verdict, then stop.
   task automatic testDone();
      $display("checks %0d mismatches %0d", testsRun, errTotal);
      if (errTotal == 0 && testsRun > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // Read a parameter with a 16-bit or 32-bit frame; bounded reply wait.
   task automatic rd(input logic [7:0] id, input int n,
                     output logic [31:0] v);
      int t;
      t = 0;
      if (n == 4) host.sendFrame($sformatf("3D%08hX", {24'h0, id}));
      else host.sendFrame($sformatf("3d%04hX", {8'h0, id}));
      while (host.got.size() < n && t < 400) begin
         @(posedge core_clk);
         t++;
      end
      v = '0;
      for (int i = 0; i < n; i++) v[8*i +: 8] = host.got.pop_front();
   endtask

   // Write a 16-bit value with a short frame.
   task automatic wr(input logic [7:0] id, input logic [15:0] d);
      host.sendFrame($sformatf("%02h%04hX", id, d));
   endtask

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   // Every parameter reads back its default after power-on.
   task automatic t_defaults();
      logic [31:0] v;
      for (int i = 0; i < N_PARAMS; i++) begin
         rd(PARAM_ID[i], 2, v);
         check(v, {16'h0, PARAM_RST[i]});
      end
      check(canCfg.canReceiveIdentifier, 16'h0201);
      check(canCfg.canTransmitIdentifier, 16'h0181);
      check(canCfg.nominalBitRate, 16'd500);
      check(canCfg.canBitTimingCode, 16'h4025);
      // The controller bundle must carry the same defaults as the reads.
      check(curCtrl.gain, 16'h000a);
      check(curCtrl.integTime, 16'h0258);
      check(curCtrl.ramp, 16'h0258);
      check(curCtrl.integralMemoryLimit, 16'h0032);
      check(curCtrl.digitalLimit, 16'h0064);
      check({curCtrl.peakLimit, curCtrl.contLimit}, 32'h0);
      check(curCtrl.overcurrentTime, 16'h0005);
   endtask

   // All bit-timing codes, identifiers, the clamped limit and speed.
   task automatic t_config();
      logic [31:0] v;
      logic [15:0] codes [4] = '{16'h4002, 16'h4025, 16'h4014, 16'h402f};
      logic [15:0] rates [4] = '{16'd1000, 16'd500, 16'd625, 16'd250};
      for (int i = 0; i < 4; i++) begin
         wr(8'h73, codes[i]);
         check(canCfg.nominalBitRate, rates[i]);
      end
      wr(8'h68, 16'h0123);
      slow <= 1'b1;
      rd(8'h68, 4, v);
      check(v, 32'h0000_0123);
      slow <= 1'b0;
      wr(8'h69, 16'h0456);
      rd(8'h69, 2, v);
      check(v, 32'h0456);
      wr(8'h2b, 16'h0065);
      rd(8'h2b, 2, v);
      check(v, 32'h0064);
      host.sendFrame("2b0000001eX");
      rd(8'h2b, 2, v);
      check(v, 32'h001e);
      check(curCtrl.integralMemoryLimit, 16'h001e);
      wr(8'h30, 16'h1111);
      rd(8'h30, 2, v);
      check(v, 32'h1234);
      speedActual <= 16'h8000;
      rd(8'h30, 2, v);
      check(v, 32'h8001);
   endtask

   // Broken frames give no reply and leave the next frame intact.
   task automatic t_bad();
      logic [31:0] v;
      host.sendFrame("3DZ030X");
      host.sendFrame("3D030X");
      host.sendFrame("3D000000000030X");
      repeat (20) @(posedge core_clk);
      check(host.got.size(), 0);
      rd(8'h1c, 2, v);
      check(v, 32'h000a);
   endtask

   // Faults from three sources, each cleared by a different event.
   task automatic t_fault();
      logic [31:0] v;
      driveEnablePin <= 1'b1;
      supplyPresentPin <= 1'b1;
      repeat (6) @(posedge core_clk);
      check({readyContact, driveGo, faultLed}, 3'b110);
      check(readyStatus, 1'b1);
      for (int k = 0; k < 3; k++) begin
         @(posedge core_clk);
         faultIn <= 8'h01 << k;
         @(posedge core_clk);
         faultIn <= 8'h00;
         // Stay on rising edges so the read below drives by the rules.
         @(posedge core_clk);
         check({readyContact, driveGo, faultLed}, 3'b001);
         check(readyStatus, 1'b0);
         rd(ID_STATUS, 2, v);
         check(v, 32'h0002);
         if (k == 0) wr(ID_CANCEL, 16'h0000);
         if (k == 1) cancelErrorPin <= 1'b1;
         if (k == 2) driveEnablePin <= 1'b0;
         repeat (5) @(posedge core_clk);
         cancelErrorPin <= 1'b0;
         driveEnablePin <= 1'b1;
         repeat (6) @(posedge core_clk);
         check({readyContact, driveGo, faultLed}, 3'b110);
      end
      rd(ID_GO, 2, v);
      check(v, 32'h0001);
   endtask

   // Ready with enable and supply off, with and without the watchdog.
   task automatic t_watch();
      @(posedge core_clk);
      driveEnablePin <= 1'b0;
      supplyPresentPin <= 1'b0;
      repeat (6) @(posedge core_clk);
      check(readyContact, 1'b1);
      readyUndervoltageSelect <= 1'b1;
      repeat (3) @(posedge core_clk);
      check(readyContact, 1'b0);
      supplyPresentPin <= 1'b1;
      repeat (6) @(posedge core_clk);
      check(readyContact, 1'b1);
   endtask

   // A second power-on clears a latched fault and the written settings.
   task automatic t_reset();
      logic [31:0] v;
      faultIn <= 8'h80;
      @(posedge core_clk);
      faultIn <= 8'h00;
      reset_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      reset_n <= 1'b1;
      // The watchdog is still selected, so ready waits until the supply
      // pin has passed the synchroniser after the release.
      repeat (4) @(posedge core_clk);
      check({readyContact, faultLed}, 2'b10);
      rd(8'h73, 2, v);
      check(v, 32'h4025);
   endtask

   // Main sequence; reset is held for three cycles.
   initial begin
      faultIn = 8'h00;
      driveEnablePin = 1'b0;
      supplyPresentPin = 1'b0;
      cancelErrorPin = 1'b0;
      readyUndervoltageSelect = 1'b0;
      speedActual = 16'h1234;
      slow = 1'b0;
      repeat (3) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      t_defaults();
      t_config();
      t_bad();
      t_fault();
      t_watch();
      t_reset();
      testDone();
   end

   // Watchdog far beyond the few hundred cycles the tests need.
   initial begin
      #200us;
      errTotal++;
      testDone();
   end
endmodule
